// ===== logic/pucl_config_loader.v
// Behaviour
// - Initialization starts after reset release, beginning with integrity checks.
// - Sequence: telemetry on, address strap, config load, fault check, ready.
// - PWM outputs stay high impedance until a rail is commanded to regulate.
// - Address strap step maps to the documented 7-bit target address.
// - Config strap step 0..15 selects the configuration identifier.
// - Twenty-eight one-time slots hold any mix of identifiers.
// - Newest slot for the selected identifier is the one loaded.
// - Programming is refused once all slots are used.
// - Configuration arrives by direct RAM write or by slot programming.
// - No stored configuration leaves the device waiting with PWM tri-stated.
// - While waiting, enables are ignored until a direct RAM load.
// - Regulation stops whenever input voltage leaves the configured window.
// - Input current is synthesized per rail; power is current times voltage.
// - Aux gating inhibits a rail once aux voltage falls below the off level, until it reaches the on level.
// - An aux-inhibited rail restarts once aux voltage returns in range.
// - Aux gating is per rail; aux input has selectable ranges.
// - Each rail enables by pin or bus command, chosen per rail.
`timescale 1ns/1ps
`include "pucl_map.vh"
module pucl_config_loader #(
   parameter CFG_W     = `PUCL_CFG_W,
   parameter NUM_SLOTS = `PUCL_NUM_SLOTS,
   parameter ADC_W     = `PUCL_ADC_W
) (
   input  wire                         clk_i,
   input  wire                         rstn_i,
   input  wire [`PUCL_STEP_W-1:0]      addr_step_i,
   input  wire [`PUCL_STEP_W-1:0]      cfg_step_i,
   input  wire                         integrity_ok_i,
   input  wire                         fault_clear_i,
   output reg                          telemetry_en_o,
   output reg  [`PUCL_ADDR_W-1:0]      pmbus_addr_o,
   output reg  [`PUCL_ID_W-1:0]        cfg_id_o,
   output reg                          init_done_o,
   output reg                          waiting_o,
   output reg                          cfg_loaded_o,
   output reg  [CFG_W-1:0]             cfg_data_o,
   input  wire                         ram_load_i,
   input  wire [CFG_W-1:0]             ram_data_i,
   input  wire                         prog_req_i,
   input  wire [`PUCL_ID_W-1:0]        prog_id_i,
   input  wire [CFG_W-1:0]             prog_data_i,
   output wire                         prog_ack_o,
   output wire                         prog_rej_o,
   output wire                         otp_full_o,
   input  wire [ADC_W-1:0]             input_voltage_sense_pin_i,
   input  wire [ADC_W-1:0]             vin_on_i,
   input  wire [ADC_W-1:0]             vin_off_i,
   input  wire [ADC_W-1:0]             vin_ov_i,
   input  wire [ADC_W-1:0]             vin_uv_i,
   input  wire [ADC_W-1:0]             aux_voltage_monitor_pin_i,
   input  wire [`PUCL_AUX_RANGE_W-1:0] aux_range_i,
   input  wire [ADC_W-1:0]             aux_monitor_turn_on_level_i,
   input  wire [ADC_W-1:0]             aux_monitor_turn_off_level_i,
   input  wire [1:0]                   aux_gate_en_i,
   input  wire [1:0]                   en_by_pin_i,
   input  wire [1:0]                   en_pin_i,
   input  wire [1:0]                   en_cmd_i,
   input  wire [1:0]                   pwm_i,
   input  wire [2*ADC_W-1:0]           iin_synth_i,
   output reg  [1:0]                   pwm_o,
   output reg  [1:0]                   pwm_oe_o,
   output reg  [1:0]                   soft_start_o,
   output reg  [1:0]                   rail_eligible_o,
   output reg  [2*ADC_W-1:0]           iin_o,
   output reg  [4*ADC_W-1:0]           pin_o
);
   localparam ST_CHECK = 3'h0;
   localparam ST_TELEM = 3'h1;
   localparam ST_STRAP = 3'h2;
   localparam ST_LOAD  = 3'h3;
   localparam ST_FAULT = 3'h4;
   localparam ST_READY = 3'h5;
   localparam ST_WAIT  = 3'h6;
   localparam       CHECK_CYC_RAW = `PUCL_CHECK_CYC;
   localparam [7:0] CHECK_CYC     = CHECK_CYC_RAW[7:0];

   reg  [2:0]               st_q;
   reg  [7:0]               cnt_q;
   reg                      vin_ok_q;
   reg  [1:0]               aux_ok_q;
   reg  [1:0]               run_q;
   wire [`PUCL_ADDR_W-1:0]  dec_addr;
   wire [`PUCL_ID_W-1:0]    dec_id;
   wire                     found;
   wire [CFG_W-1:0]         found_data;
   wire [ADC_W-1:0]         aux_scaled;
   wire [1:0]               en_req;
   wire [1:0]               eligible;

   pucl_strap_decode u_dec (
      .addr_step_i  (addr_step_i),
      .cfg_step_i   (cfg_step_i),
      .pmbus_addr_o (dec_addr),
      .cfg_id_o     (dec_id)
   );

   pucl_otp_store #(
      .NUM_SLOTS (NUM_SLOTS),
      .CFG_W     (CFG_W)
   ) u_otp (
      .clk_i        (clk_i),
      .rstn_i       (rstn_i),
      .prog_req_i   (prog_req_i),
      .prog_id_i    (prog_id_i),
      .prog_data_i  (prog_data_i),
      .prog_ack_o   (prog_ack_o),
      .prog_rej_o   (prog_rej_o),
      .full_o       (otp_full_o),
      .find_id_i    (cfg_id_o),
      .found_o      (found),
      .found_data_o (found_data)
   );

   // Sequencer
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q           <= ST_CHECK;
         cnt_q          <= 8'h00;
         telemetry_en_o <= 1'b0;
         pmbus_addr_o   <= 7'h00;
         cfg_id_o       <= 4'h0;
         init_done_o    <= 1'b0;
         waiting_o      <= 1'b0;
         cfg_loaded_o   <= 1'b0;
         cfg_data_o     <= {CFG_W{1'b0}};
      end else begin
         case (st_q)
            ST_CHECK: begin
               // Integrity check runs a minimum time, then needs a pass
               if (cnt_q < CHECK_CYC)
                  cnt_q <= cnt_q + 8'h01;
               else if (integrity_ok_i)
                  st_q <= ST_TELEM;
            end
            ST_TELEM: begin
               telemetry_en_o <= 1'b1;
               st_q           <= ST_STRAP;
            end
            ST_STRAP: begin
               pmbus_addr_o <= dec_addr;
               cfg_id_o     <= dec_id;
               st_q         <= ST_LOAD;
            end
            ST_LOAD: begin
               if (found) begin
                  cfg_data_o   <= found_data;
                  cfg_loaded_o <= 1'b1;
                  st_q         <= ST_FAULT;
               end else begin
                  waiting_o <= 1'b1;
                  st_q      <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Only a direct RAM load releases the wait; a fresh slot
               // programmed now is picked up at the next power-up
               if (ram_load_i) begin
                  cfg_data_o   <= ram_data_i;
                  cfg_loaded_o <= 1'b1;
                  waiting_o    <= 1'b0;
                  st_q         <= ST_FAULT;
               end
            end
            ST_FAULT: begin
               if (fault_clear_i)
                  st_q <= ST_READY;
            end
            ST_READY: begin
               init_done_o <= 1'b1;
               if (ram_load_i)
                  cfg_data_o <= ram_data_i;
            end
            default: begin
               st_q <= ST_CHECK;
            end
         endcase
      end
   end

   // Aux range shifts the reading to a common scale
   assign aux_scaled = aux_voltage_monitor_pin_i >> aux_range_i;

   // Window monitors with hysteresis between on and off levels
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vin_ok_q <= 1'b0;
         aux_ok_q <= 2'h0;
      end else begin
         if ((input_voltage_sense_pin_i >= vin_ov_i) ||
             (input_voltage_sense_pin_i <= vin_uv_i) ||
             (input_voltage_sense_pin_i < vin_off_i))
            vin_ok_q <= 1'b0;
         else if (input_voltage_sense_pin_i >= vin_on_i)
            vin_ok_q <= 1'b1;
         if (aux_scaled < aux_monitor_turn_off_level_i)
            aux_ok_q <= 2'h0;
         else if (aux_scaled >= aux_monitor_turn_on_level_i)
            aux_ok_q <= 2'h3;
      end
   end

   genvar r;
   generate
      for (r = 0; r < 2; r = r + 1) begin : g_rail
         assign en_req[r]   = en_by_pin_i[r] ? en_pin_i[r] : en_cmd_i[r];
         assign eligible[r] = cfg_loaded_o && init_done_o && vin_ok_q &&
                              (!aux_gate_en_i[r] || aux_ok_q[r]);

         always @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               run_q[r]           <= 1'b0;
               soft_start_o[r]    <= 1'b0;
               rail_eligible_o[r] <= 1'b0;
               pwm_o[r]           <= 1'b0;
               pwm_oe_o[r]        <= 1'b0;
               iin_o[r*ADC_W +: ADC_W]     <= {ADC_W{1'b0}};
               pin_o[r*2*ADC_W +: 2*ADC_W] <= {2*ADC_W{1'b0}};
            end else begin
               rail_eligible_o[r] <= eligible[r];
               // Rail drops out when ineligible and restarts when eligible
               run_q[r]        <= en_req[r] && eligible[r];
               soft_start_o[r] <= en_req[r] && eligible[r] && !run_q[r];
               pwm_oe_o[r]     <= en_req[r] && eligible[r];
               pwm_o[r]        <= pwm_i[r] && en_req[r] && eligible[r];
               if (telemetry_en_o) begin
                  iin_o[r*ADC_W +: ADC_W] <= iin_synth_i[r*ADC_W +: ADC_W];
                  pin_o[r*2*ADC_W +: 2*ADC_W] <=
                     iin_synth_i[r*ADC_W +: ADC_W] * input_voltage_sense_pin_i;
               end
            end
         end
      end
   endgenerate
endmodule

// ===== logic/pucl_map.vh
`ifndef PUCL_MAP_VH
`define PUCL_MAP_VH
`define PUCL_NUM_SLOTS      28
`define PUCL_SLOT_W         5
`define PUCL_ID_W           4
`define PUCL_CFG_W          32
`define PUCL_ADDR_W         7
`define PUCL_STEP_W         5
`define PUCL_ADC_W          12
`define PUCL_ADDR_BASE_LO   7'h60
`define PUCL_ADDR_BASE_MID  7'h45
`define PUCL_ADDR_BASE_HI   7'h4C
`define PUCL_ADDR_BASE_TOP  7'h50
`define PUCL_ADDR_LAST      7'h68
`define PUCL_CHECK_NS       100
`define PUCL_CHECK_CYC      ((`PUCL_CHECK_NS + 4) / 5)
`define PUCL_AUX_RANGE_W    2
`endif

// ===== logic/pucl_strap_decode.v
`timescale 1ns/1ps
`include "pucl_map.vh"
module pucl_strap_decode (
   input  wire [`PUCL_STEP_W-1:0] addr_step_i,
   input  wire [`PUCL_STEP_W-1:0] cfg_step_i,
   output wire [`PUCL_ADDR_W-1:0] pmbus_addr_o,
   output wire [`PUCL_ID_W-1:0]   cfg_id_o
);
   function [`PUCL_ADDR_W-1:0] step_to_addr;
      input [`PUCL_STEP_W-1:0] s;
      begin
         if (s <= 5'h07)
            step_to_addr = `PUCL_ADDR_BASE_LO + {2'h0, s};
         else if (s <= 5'h0A)
            step_to_addr = `PUCL_ADDR_BASE_MID + {2'h0, s - 5'h08};
         else if (s <= 5'h0E)
            step_to_addr = `PUCL_ADDR_BASE_HI + {2'h0, s - 5'h0B};
         else if (s <= 5'h1E)
            step_to_addr = `PUCL_ADDR_BASE_TOP + {2'h0, s - 5'h0F};
         else
            step_to_addr = `PUCL_ADDR_LAST;
      end
   endfunction
   assign pmbus_addr_o = step_to_addr(addr_step_i);
   // Steps above 15 clamp to the highest identifier
   assign cfg_id_o = cfg_step_i[4] ? 4'hF : cfg_step_i[3:0];
endmodule

// ===== logic/pucl_otp_store.v
`timescale 1ns/1ps
`include "pucl_map.vh"
module pucl_otp_store #(
   parameter NUM_SLOTS = `PUCL_NUM_SLOTS,
   parameter CFG_W     = `PUCL_CFG_W
) (
   input  wire                    clk_i,
   input  wire                    rstn_i,
   input  wire                    prog_req_i,
   input  wire [`PUCL_ID_W-1:0]   prog_id_i,
   input  wire [CFG_W-1:0]        prog_data_i,
   output reg                     prog_ack_o,
   output reg                     prog_rej_o,
   output wire                    full_o,
   input  wire [`PUCL_ID_W-1:0]   find_id_i,
   output reg                     found_o,
   output reg  [CFG_W-1:0]        found_data_o
);
   reg  [CFG_W-1:0]        data_q [0:NUM_SLOTS-1];
   reg  [`PUCL_ID_W-1:0]   id_q   [0:NUM_SLOTS-1];
   // Fill count is fuse state: blank at start and kept through reset, so the
   // next power-up load still finds every slot written before it
   reg  [`PUCL_SLOT_W:0]   used_q = 6'h00;
   integer i;
   assign full_o = (used_q == NUM_SLOTS);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prog_ack_o <= 1'b0;
         prog_rej_o <= 1'b0;
      end else begin
         prog_ack_o <= 1'b0;
         prog_rej_o <= 1'b0;
         if (prog_req_i) begin
            if (full_o) begin
               prog_rej_o <= 1'b1;
            end else begin
               prog_ack_o <= 1'b1;
            end
         end
      end
   end
   // Array holds no reset; used_q bounds which slots are valid
   always @(posedge clk_i) begin
      if (prog_req_i && !full_o) begin
         data_q[used_q[`PUCL_SLOT_W-1:0]] <= prog_data_i;
         id_q[used_q[`PUCL_SLOT_W-1:0]]   <= prog_id_i;
         used_q                           <= used_q + 6'h01;
      end
   end
   // Later slots overwrite earlier matches, so the newest wins
   always @* begin
      found_o      = 1'b0;
      found_data_o = {CFG_W{1'b0}};
      for (i = 0; i < NUM_SLOTS; i = i + 1) begin
         if ((i < used_q) && (id_q[i] == find_id_i)) begin
            found_o      = 1'b1;
            found_data_o = data_q[i];
         end
      end
   end
endmodule

// ===== verification/pucl_config_loader_chk.sv
`timescale 1ns/1ps
module pucl_config_loader_chk (
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic        waiting_o,
   input wire logic        cfg_loaded_o,
   input wire logic        init_done_o,
   input wire logic        telemetry_en_o,
   input wire logic [6:0]  pmbus_addr_o,
   input wire logic [3:0]  cfg_id_o,
   input wire logic        prog_req_i,
   input wire logic        otp_full_o,
   input wire logic        prog_ack_o,
   input wire logic        prog_rej_o,
   input wire logic [1:0]  pwm_oe_o,
   input wire logic [1:0]  soft_start_o,
   input wire logic [1:0]  rail_eligible_o,
   input wire logic [11:0] input_voltage_sense_pin_i,
   input wire logic [11:0] vin_ov_i,
   input wire logic [1:0]  aux_gate_en_i,
   input wire logic [11:0] aux_voltage_monitor_pin_i,
   input wire logic [1:0]  aux_range_i,
   input wire logic [11:0] aux_monitor_turn_off_level_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   wait_tristate_a: assert property (waiting_o |-> pwm_oe_o == 2'b00)
      else $error("pwm driven while waiting");
   drive_needs_cfg_a: assert property (pwm_oe_o != 2'b00 |-> cfg_loaded_o && init_done_o)
      else $error("pwm driven without configuration");
   elig_needs_cfg_a: assert property (rail_eligible_o != 2'b00 |-> cfg_loaded_o && init_done_o)
      else $error("rail eligible before ready");
   telem_first_a: assert property (init_done_o |-> telemetry_en_o)
      else $error("ready without telemetry");
   strap_held_a: assert property (
      init_done_o |=> $stable(pmbus_addr_o) && $stable(cfg_id_o))
      else $error("strap result changed");
   prog_taken_a: assert property (prog_req_i && !otp_full_o |=> prog_ack_o && !prog_rej_o)
      else $error("program not acknowledged");
   prog_refused_a: assert property (prog_req_i && otp_full_o |=> prog_rej_o && !prog_ack_o)
      else $error("program accepted when full");
   start_pulse_a: assert property ($rose(pwm_oe_o[0]) |-> soft_start_o[0])
      else $error("no soft start on enable");
   vin_elig_a: assert property (
      (input_voltage_sense_pin_i >= vin_ov_i)[*2] |=> rail_eligible_o == 2'b00)
      else $error("eligible above overvoltage");
   vin_drive_a: assert property (
      (input_voltage_sense_pin_i >= vin_ov_i)[*3] |=> pwm_oe_o == 2'b00)
      else $error("driving above overvoltage");
   aux_gate_a: assert property (
      (aux_gate_en_i[0] && (aux_voltage_monitor_pin_i >> aux_range_i)
      < aux_monitor_turn_off_level_i)[*2] |=> !rail_eligible_o[0])
      else $error("rail eligible with aux low");
endmodule
bind pucl_config_loader pucl_config_loader_chk u_chk (.clk_i, .rstn_i, .waiting_o, .cfg_loaded_o,
   .init_done_o, .telemetry_en_o, .pmbus_addr_o, .cfg_id_o, .prog_req_i, .otp_full_o, .prog_ack_o,
   .prog_rej_o, .pwm_oe_o, .soft_start_o, .rail_eligible_o, .input_voltage_sense_pin_i, .vin_ov_i,
   .aux_gate_en_i, .aux_voltage_monitor_pin_i, .aux_range_i, .aux_monitor_turn_off_level_i);

// ===== verification/pucl_host_model.sv
`timescale 1ns/1ps
module pucl_host_model (
   input  wire logic        clk_i,
   input  wire logic        prog_ack_i,
   input  wire logic        prog_rej_i,
   output logic             prog_req_o,
   output logic [3:0]       prog_id_o,
   output logic [31:0]      prog_data_o,
   output logic             ram_load_o,
   output logic [31:0]      ram_data_o
);
   logic acked;
   logic rejd;
   initial begin
      prog_req_o = 1'b0;
      ram_load_o = 1'b0;
      prog_id_o = 4'h0;
      prog_data_o = 32'h0;
      ram_data_o = 32'h0;
   end
   // Random idle cycles so the device sees both prompt and slow hosts
   task prog(input logic [3:0] id, input logic [31:0] d);
      repeat (1 + $urandom % 3) @(negedge clk_i);
      prog_id_o = id;
      prog_data_o = d;
      prog_req_o = 1'b1;
      @(negedge clk_i);
      acked = prog_ack_i;
      rejd = prog_rej_i;
      prog_req_o = 1'b0;
      prog_data_o = ~d;
   endtask
   task ram(input logic [31:0] d);
      repeat (1 + $urandom % 3) @(negedge clk_i);
      ram_data_o = d;
      ram_load_o = 1'b1;
      @(negedge clk_i);
      ram_load_o = 1'b0;
      ram_data_o = ~d;
   endtask
endmodule

// ===== verification/tb_pucl_config_loader.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WT(c) begin k = 0; while (!(c) && k < 300) begin @(negedge clk_i); k++; end \
   if (!(c)) begin error_cnt++; complete_run; end end
module tb_pucl_config_loader;
   logic        clk_i = 0, rstn_i = 0, integrity_ok_i = 1, fault_clear_i = 1;
   logic [4:0]  addr_step_i = 0, cfg_step_i = 0;
   logic [11:0] input_voltage_sense_pin_i = 12'h800, aux_voltage_monitor_pin_i = 12'h800;
   logic [11:0] vin_on_i = 12'h400, vin_off_i = 12'h300, vin_ov_i = 12'hE00, vin_uv_i = 12'h200;
   logic [11:0] aux_monitor_turn_on_level_i = 12'h400, aux_monitor_turn_off_level_i = 12'h300;
   logic [1:0]  aux_range_i = 0, aux_gate_en_i = 0, en_by_pin_i = 2'b10, en_pin_i = 0;
   logic [1:0]  en_cmd_i = 0, pwm_i = 0;
   logic [23:0] iin_synth_i = 0;
   wire         ram_load_i, prog_req_i, prog_ack_o, prog_rej_o, otp_full_o;
   wire         telemetry_en_o, init_done_o, waiting_o, cfg_loaded_o;
   wire [3:0]   prog_id_i, cfg_id_o;
   wire [31:0]  ram_data_i, prog_data_i, cfg_data_o;
   wire [6:0]   pmbus_addr_o;
   wire [1:0]   pwm_o, pwm_oe_o, soft_start_o, rail_eligible_o;
   wire [23:0]  iin_o;
   wire [47:0]  pin_o;
   int          error_cnt = 0, compares = 0, k, i;
   logic [31:0] newest;
   logic [3:0]  sel;
   always #2.5 clk_i = ~clk_i;
   always @(negedge clk_i) begin
      pwm_i <= $urandom;
      iin_synth_i <= $urandom;
   end
   pucl_config_loader DUT (.clk_i, .rstn_i, .addr_step_i, .cfg_step_i, .integrity_ok_i,
      .fault_clear_i, .telemetry_en_o, .pmbus_addr_o, .cfg_id_o, .init_done_o, .waiting_o,
      .cfg_loaded_o, .cfg_data_o, .ram_load_i, .ram_data_i, .prog_req_i, .prog_id_i, .prog_data_i,
      .prog_ack_o, .prog_rej_o, .otp_full_o, .input_voltage_sense_pin_i, .vin_on_i, .vin_off_i,
      .vin_ov_i, .vin_uv_i, .aux_voltage_monitor_pin_i, .aux_range_i, .aux_monitor_turn_on_level_i,
      .aux_monitor_turn_off_level_i, .aux_gate_en_i, .en_by_pin_i, .en_pin_i, .en_cmd_i, .pwm_i,
      .iin_synth_i, .pwm_o, .pwm_oe_o, .soft_start_o, .rail_eligible_o, .iin_o, .pin_o);
   pucl_host_model host (.clk_i, .prog_ack_i(prog_ack_o), .prog_rej_i(prog_rej_o),
      .prog_req_o(prog_req_i), .prog_id_o(prog_id_i), .prog_data_o(prog_data_i),
      .ram_load_o(ram_load_i), .ram_data_o(ram_data_i));
   function automatic logic [6:0] exp_addr(input int s);
      if (s < 8) return 7'h60 + 7'(s);
      if (s < 11) return 7'h45 + 7'(s - 8);
      if (s < 15) return 7'h4C + 7'(s - 11);
      if (s < 31) return 7'h50 + 7'(s - 15);
      return 7'h68;
   endfunction
   function automatic logic [47:0] exp_pin(input logic [23:0] cur, input logic [11:0] v);
      return {24'(cur[23:12]) * 24'(v), 24'(cur[11:0]) * 24'(v)};
   endfunction
   task reset;
      rstn_i = 0;
      repeat (12) @(negedge clk_i);
      rstn_i = 1;
   endtask
   task complete_run;
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h3a07));
      reset;
      `WT(waiting_o || cfg_loaded_o)
      `CHK(waiting_o, 1'b1)
      en_cmd_i = 2'b01;
      en_pin_i = 2'b10;
      repeat (6) @(negedge clk_i);
      `CHK(pwm_oe_o, 2'b00)
      newest = $urandom;
      host.ram(newest);
      `WT(init_done_o)
      `CHK(cfg_data_o, newest)
      `WT(pwm_oe_o == 2'b11)
      `CHK(soft_start_o, 2'b11)
      `CHK(pwm_o, pwm_i)
      `CHK(iin_o, iin_synth_i)
      `CHK(pin_o, exp_pin(iin_synth_i, input_voltage_sense_pin_i))
      newest = $urandom;
      host.ram(newest);
      `CHK(cfg_data_o, newest)
      input_voltage_sense_pin_i = 12'hF00;
      `WT(pwm_oe_o == 2'b00)
      `CHK(rail_eligible_o, 2'b00)
      input_voltage_sense_pin_i = 12'h800;
      `WT(rail_eligible_o == 2'b11)
      // Only rail 0 watches the aux level, so rail 1 must stay eligible
      aux_gate_en_i = 2'b01;
      aux_voltage_monitor_pin_i = 12'h100;
      `WT(rail_eligible_o != 2'b11)
      `CHK(rail_eligible_o, 2'b10)
      aux_voltage_monitor_pin_i = 12'h800;
      `WT(rail_eligible_o == 2'b11)
      `CHK(pwm_oe_o, 2'b11)
      aux_range_i = 2'h2;
      `WT(rail_eligible_o != 2'b11)
      `CHK(rail_eligible_o, 2'b10)
      aux_range_i = 2'h0;
      // Each rail now asks by the method it is not configured for
      en_cmd_i = 2'b10;
      en_pin_i = 2'b01;
      repeat (3) @(negedge clk_i);
      `CHK(pwm_oe_o, 2'b00)
      en_cmd_i = 0;
      en_pin_i = 0;
      for (i = 0; i < 32; i++) begin
         addr_step_i = 5'(i);
         cfg_step_i = 5'(i);
         reset;
         `WT(waiting_o || cfg_loaded_o)
         addr_step_i = 5'(~i);
         cfg_step_i = 5'(~i);
         repeat (3) @(negedge clk_i);
         `CHK(pmbus_addr_o, exp_addr(i))
         `CHK(cfg_id_o, (i > 15) ? 4'hF : 4'(i))
      end
      sel = $urandom;
      for (i = 0; i < 28; i++) begin
         newest = $urandom;
         host.prog((i == 2 || i == 27) ? sel : 4'($urandom), newest);
         `CHK(host.acked, 1'b1)
      end
      `CHK(otp_full_o, 1'b1)
      host.prog(sel, ~newest);
      `CHK({host.rejd, host.acked}, 2'b10)
      cfg_step_i = {1'b0, sel};
      integrity_ok_i = 0;
      fault_clear_i = 0;
      reset;
      repeat (40) @(negedge clk_i);
      `CHK(telemetry_en_o, 1'b0)
      integrity_ok_i = 1;
      `WT(waiting_o || cfg_loaded_o)
      `CHK(cfg_data_o, newest)
      `CHK(cfg_loaded_o, 1'b1)
      repeat (4) @(negedge clk_i);
      `CHK(init_done_o, 1'b0)
      fault_clear_i = 1;
      `WT(init_done_o)
      `CHK(telemetry_en_o, 1'b1)
      complete_run;
   end
endmodule
